// >>> mac_phy_params.svh
// Constants for the PHY-side shell of the MAC: frame layout of the
// management serial line, speed codes and in-band status bit positions.
// Assumes inclusion by bare name from the design files.
`ifndef MAC_PHY_PARAMS_SVH
`define MAC_PHY_PARAMS_SVH

`define SPEED_10        2'h0
`define SPEED_100       2'h1
`define SPEED_1000      2'h2
`define MDIO_FRAME_BITS 7'h40
`define MDIO_TA_BIT     7'h2E
`define MDIO_DATA_BIT   7'h30
`define MDIO_PREAMBLE   32'hFFFFFFFF
`define MDIO_START      2'h1
`define MDIO_OP_READ    2'h2
`define MDIO_OP_WRITE   2'h1
`define MDIO_TA_WRITE   2'h2
`define INB_LINK_BIT    0
`define INB_SPEED_LO    1
`define INB_DUPLEX_BIT  3

`endif

// >>> mac_phy_pkg.sv
// Types shared by the PHY-side shell of the MAC.
// Assumes the constants header is compiled alongside.
package mac_phy_pkg;
  typedef enum logic [1:0] {MEDIA_GMII, MEDIA_MII, MEDIA_RGMII} media_e;
  typedef enum logic {MG_IDLE, MG_SHIFT} mgmt_state_e;
endpackage

// >>> pin_sampler.sv
// Two-stage synchroniser for a group of pins, with a third stage kept
// for edge detection. Assumes the pins are asynchronous to clock.
`timescale 1ns/10ps
`default_nettype none

module pin_sampler #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pinIn,
  output var  logic [W-1:0] syncOut,
  output var  logic [W-1:0] prevOut
);
  logic [W-1:0] meta_ff;

  // The first stage feeds only the second; edges use stages two and three.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_ff <= '0;
      syncOut <= '0;
      prevOut <= '0;
    end else begin
      meta_ff <= pinIn;
      syncOut <= meta_ff;
      prevOut <= syncOut;
    end
  end
endmodule

`default_nettype wire

// >>> mac_phy_mgmt_interface.sv
// PHY-side shell of the MAC: media data paths, in-band status and the
// management serial line. Assumes PHY clocks and pins are asynchronous
// and are oversampled by clock; configuration comes from vector inputs.
`timescale 1ns/10ps
`default_nettype none
`include "mac_phy_params.svh"

module mac_phy_mgmt_interface
  import mac_phy_pkg::*;
#(
  parameter media_e MEDIA        = MEDIA_GMII,
  parameter bit     MGMT_PRESENT = 1'b1
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire logic [1:0]  cfgSpeed,
  input  wire logic        cfgTxEnable,
  input  wire logic        cfgRxEnable,
  input  wire logic        cfgTxReset,
  input  wire logic        cfgRxReset,
  input  wire logic [5:0]  cfgMdcDivide,
  input  wire logic        gtxTick,
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  input  wire logic        txLast,
  input  wire logic        txUserErr,
  output logic             txReady,
  output var  logic        rxValid,
  output var  logic [7:0]  rxData,
  output var  logic        rxErr,
  output var  logic        rxLast,
  output logic             speed_hundred_ind,
  output logic             speed_low_rate_ind,
  output var  logic [7:0]  phyTxd,
  output var  logic        phyTxEn,
  output var  logic        phyTxEr,
  input  wire logic        phyTxClk,
  input  wire logic        phyRxClk,
  input  wire logic [7:0]  phyRxd,
  input  wire logic        phyRxDv,
  input  wire logic        phyRxEr,
  output var  logic        inbandLinkStatus,
  output var  logic [1:0]  inbandClockSpeed,
  output var  logic        inbandDuplexStatus,
  input  wire logic        mgmtStart,
  input  wire logic        mgmtRead,
  input  wire logic [4:0]  mgmtPhyAddr,
  input  wire logic [4:0]  mgmtRegAddr,
  input  wire logic [15:0] mgmtWrData,
  output logic             mgmtBusy,
  output var  logic [15:0] mgmtRdData,
  output logic             mdc,
  input  wire logic        mdioIn,
  output logic             mdioOut,
  output logic             mdioTristate
);
  // ********************************************************************
  // Pin sampling
  // ********************************************************************
  logic [11:0] rxSync;
  logic [11:0] rxPrev;
  logic [1:0]  miscSync;
  logic [1:0]  miscPrev;

  pin_sampler #(.W(12)) rxSampler (
    .clock   (clock),
    .reset_n (reset_n),
    .pinIn   ({phyRxClk, phyRxDv, phyRxEr, phyRxd, 1'b0}),
    .syncOut (rxSync),
    .prevOut (rxPrev)
  );

  pin_sampler #(.W(2)) miscSampler (
    .clock   (clock),
    .reset_n (reset_n),
    .pinIn   ({phyTxClk, mdioIn}),
    .syncOut (miscSync),
    .prevOut (miscPrev)
  );

  // Clocks arrive as data, so the PHY clock must stay well below clock/4.
  wire       rxTick  = rxSync[11] & ~rxPrev[11];
  wire       rxDvS   = rxSync[10];
  wire       rxErS   = rxSync[9];
  wire [7:0] rxdS    = rxSync[8:1];
  wire       txTickP = miscSync[1] & ~miscPrev[1];
  wire       mdioS   = miscSync[0];
  wire       nibMode = (MEDIA != MEDIA_GMII);

  // ********************************************************************
  // Transmit path
  // ********************************************************************
  logic       txBusy_ff;
  logic       txHi_ff;
  logic       txHoldLast_ff;
  logic [3:0] txHold_ff;
  logic [1:0] txSpeed_ff;

  // Speed stays frozen for a whole frame and follows the vector between.
  wire [1:0] txSpeedNow = txBusy_ff ? txSpeed_ff : cfgSpeed;
  wire       gigMode    = (txSpeedNow == `SPEED_1000) && !nibMode;
  wire       txTick     = gigMode ? gtxTick : txTickP;
  wire       txOpen     = txBusy_ff | cfgTxEnable;
  assign txReady = txTick & ~txHi_ff & txOpen & ~cfgTxReset;
  wire       txTake     = txReady & txValid;
  wire       txEndNow   = txTake & txLast & ~nibMode;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      txBusy_ff     <= 1'b0;
      txHi_ff       <= 1'b0;
      txHoldLast_ff <= 1'b0;
      txHold_ff     <= 4'h0;
      txSpeed_ff    <= `SPEED_1000;
      phyTxd        <= 8'h00;
      phyTxEn       <= 1'b0;
      phyTxEr       <= 1'b0;
    end else if (cfgTxReset) begin
      txBusy_ff <= 1'b0;
      txHi_ff   <= 1'b0;
      phyTxEn   <= 1'b0;
      phyTxEr   <= 1'b0;
    end else if (txTick) begin
      if (txHi_ff) begin
        phyTxd    <= {4'h0, txHold_ff};
        txHi_ff   <= 1'b0;
        txBusy_ff <= ~txHoldLast_ff;
      end else if (txTake) begin
        if (!txBusy_ff) begin
          txSpeed_ff <= cfgSpeed;
        end
        phyTxd        <= nibMode ? {4'h0, txData[3:0]} : txData;
        txHold_ff     <= txData[7:4];
        txHi_ff       <= nibMode;
        txHoldLast_ff <= txLast;
        txBusy_ff     <= ~txEndNow;
        phyTxEr       <= txUserErr;
      end else begin
        phyTxEr <= 1'b0;
      end
      phyTxEn <= txHi_ff | txTake;
    end
  end

  // ********************************************************************
  // Receive path and in-band status
  // ********************************************************************
  logic       rxBusy_ff;
  logic       rxOn_ff;
  logic       rxHi_ff;
  logic [3:0] rxLow_ff;

  // The first byte of a frame is judged by the enable it meets at the
  // start tick, since the latched copy still belongs to the last frame.
  wire rxOnNow   = rxBusy_ff ? rxOn_ff : cfgRxEnable;
  wire rxHiNow   = rxBusy_ff & rxHi_ff;
  wire rxDeliver = rxTick & rxDvS & rxOnNow;
  wire rxByteOut = rxDeliver & (~nibMode | rxHiNow);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rxBusy_ff <= 1'b0;
      rxOn_ff   <= 1'b0;
      rxHi_ff   <= 1'b0;
      rxLow_ff  <= 4'h0;
      rxValid   <= 1'b0;
      rxData    <= 8'h00;
      rxErr     <= 1'b0;
      rxLast    <= 1'b0;
    end else if (cfgRxReset) begin
      rxBusy_ff <= 1'b0;
      rxOn_ff   <= 1'b0;
      rxHi_ff   <= 1'b0;
      rxValid   <= 1'b0;
      rxLast    <= 1'b0;
    end else begin
      rxValid <= rxByteOut;
      rxLast  <= rxTick & ~rxDvS & rxBusy_ff & rxOn_ff;
      if (rxTick) begin
        rxBusy_ff <= rxDvS;
        if (rxDvS && !rxBusy_ff) begin
          rxOn_ff <= cfgRxEnable;
          rxHi_ff <= 1'b0;
        end
      end
      if (rxDeliver && nibMode && !rxHiNow) begin
        rxLow_ff <= rxdS[3:0];
        rxHi_ff  <= 1'b1;
      end else if (rxByteOut) begin
        rxData  <= nibMode ? {rxdS[3:0], rxLow_ff} : rxdS;
        rxHi_ff <= 1'b0;
      end
      if (rxDeliver) begin
        rxErr <= rxErS;
      end
    end
  end

  // In-band status is only meaningful while no frame is on the wire.
  wire inbandTake = (MEDIA == MEDIA_RGMII) && rxTick && !rxDvS;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      inbandLinkStatus   <= 1'b0;
      inbandClockSpeed   <= `SPEED_10;
      inbandDuplexStatus <= 1'b0;
    end else if (inbandTake) begin
      inbandLinkStatus   <= rxdS[`INB_LINK_BIT];
      inbandClockSpeed   <= rxdS[`INB_SPEED_LO +: 2];
      inbandDuplexStatus <= rxdS[`INB_DUPLEX_BIT];
    end
  end

  // No register bank is built the vector inputs stand in for it.
  // Configuration vector drives the speed indications directly.
  assign speed_hundred_ind  = (cfgSpeed == `SPEED_100);
  assign speed_low_rate_ind = (cfgSpeed == `SPEED_10) ||
                              (cfgSpeed == `SPEED_100);

  // ********************************************************************
  // Management serial line
  // ********************************************************************
  mgmt_state_e mgState_ff;
  logic [5:0]  mdcCount_ff;
  logic        mdc_ff;
  logic [6:0]  bitIdx_ff;
  logic [63:0] shift_ff;
  logic        mgRead_ff;
  logic        drive_ff;

  wire mdcHalf = (cfgMdcDivide != 6'h00) && (mdcCount_ff == cfgMdcDivide);
  wire mdcFall = mdcHalf & mdc_ff;
  wire mdcRise = mdcHalf & ~mdc_ff;
  wire lastBit = (bitIdx_ff == (`MDIO_FRAME_BITS - 7'h01));
  wire [1:0] opCode = mgmtRead ? `MDIO_OP_READ : `MDIO_OP_WRITE;
  wire [63:0] frameWord = {`MDIO_PREAMBLE, `MDIO_START, opCode,
                           mgmtPhyAddr, mgmtRegAddr, `MDIO_TA_WRITE,
                           mgmtWrData};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mdcCount_ff <= 6'h00;
      mdc_ff      <= 1'b0;
    end else if (mdcHalf || cfgMdcDivide == 6'h00) begin
      mdcCount_ff <= 6'h00;
      mdc_ff      <= (cfgMdcDivide != 6'h00) & ~mdc_ff;
    end else begin
      mdcCount_ff <= mdcCount_ff + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mgState_ff <= MG_IDLE;
      bitIdx_ff  <= 7'h00;
      shift_ff   <= 64'h0;
      mgRead_ff  <= 1'b0;
      drive_ff   <= 1'b0;
      mgmtRdData <= 16'h0000;
    end else begin
      case (mgState_ff)
        MG_IDLE: begin
          if (mgmtStart && MGMT_PRESENT && mdcFall) begin
            mgState_ff <= MG_SHIFT;
            shift_ff   <= frameWord;
            mgRead_ff  <= mgmtRead;
            bitIdx_ff  <= 7'h00;
            drive_ff   <= 1'b1;
          end
        end
        MG_SHIFT: begin
          if (mdcRise && mgRead_ff && bitIdx_ff >= `MDIO_DATA_BIT) begin
            mgmtRdData <= {mgmtRdData[14:0], mdioS};
          end
          if (mdcFall) begin
            if (lastBit) begin
              mgState_ff <= MG_IDLE;
              drive_ff   <= 1'b0;
            end else begin
              bitIdx_ff <= bitIdx_ff + 7'h01;
              shift_ff  <= {shift_ff[62:0], 1'b0};
              if (mgRead_ff && bitIdx_ff + 7'h01 == `MDIO_TA_BIT) begin
                drive_ff <= 1'b0;
              end
            end
          end
        end
        default: mgState_ff <= MG_IDLE;
      endcase
    end
  end

  // Without the option the pins stay idle: clock low, line released.
  assign mdc          = MGMT_PRESENT & mdc_ff;
  assign mgmtBusy     = (mgState_ff == MG_SHIFT);
  assign mdioOut      = MGMT_PRESENT & shift_ff[63];
  assign mdioTristate = ~(MGMT_PRESENT & drive_ff);
endmodule

`default_nettype wire

// >>> mac_phy_mgmt_interface_sva.sv
// Checker for the PHY-side shell, bound to the top module's ports.
// Assumes one clock domain and frames started with mgmtRead held.
`timescale 1ns/10ps
`default_nettype none
module mac_phy_mgmt_interface_sva (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic [1:0] cfgSpeed,
  input wire logic       cfgTxReset,
  input wire logic       txValid,
  input wire logic       txReady,
  input wire logic [7:0] txData,
  input wire logic       txUserErr,
  input wire logic [7:0] phyTxd,
  input wire logic       phyTxEn,
  input wire logic       phyTxEr,
  input wire logic       rxValid,
  input wire logic       speed_hundred_ind,
  input wire logic       speed_low_rate_ind,
  input wire logic       mgmtRead,
  input wire logic       mgmtBusy,
  input wire logic       mdc,
  input wire logic       mdioTristate
);
  // ****************************************
  // Assertions
  // ****************************************
  // The rise count lags mdc by one cycle, so the bounds keep a margin.
  logic [6:0] riseCnt_ff;
  logic       mdcQ_ff;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      riseCnt_ff <= 7'h00;
      mdcQ_ff    <= 1'b0;
    end else begin
      mdcQ_ff    <= mdc;
      riseCnt_ff <= !mgmtBusy ? 7'h00 : riseCnt_ff + {6'h00, mdc & !mdcQ_ff};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_spd100; speed_hundred_ind == (cfgSpeed == 2'h1); endproperty
  property p_spdlow; speed_low_rate_ind == (cfgSpeed <= 2'h1); endproperty
  property p_txrst; cfgTxReset |-> !txReady; endproperty
  property p_txout;
    txValid && txReady |=> phyTxEn && phyTxd == $past(txData)
      && phyTxEr == $past(txUserErr);
  endproperty
  property p_rxpulse; rxValid |=> !rxValid; endproperty
  property p_idle; !mgmtBusy && !$past(mgmtBusy) |-> mdioTristate; endproperty
  property p_wrdrive; mgmtBusy && !mgmtRead |-> !mdioTristate; endproperty
  property p_rdearly;
    mgmtBusy && mgmtRead && riseCnt_ff <= 7'h2D |-> !mdioTristate;
  endproperty
  property p_rdrel;
    mgmtBusy && mgmtRead && riseCnt_ff >= 7'h2F |-> mdioTristate;
  endproperty
  property p_frame; $fell(mgmtBusy) |-> riseCnt_ff == 7'h40; endproperty
  a_spd100: assert property (p_spd100) else $error("hundred flag");
  a_spdlow: assert property (p_spdlow) else $error("low rate flag");
  a_txrst: assert property (p_txrst) else $error("ready in reset");
  a_txout: assert property (p_txout) else $error("tx byte lost");
  a_rxpulse: assert property (p_rxpulse) else $error("rx pulse");
  a_idle: assert property (p_idle) else $error("line held idle");
  a_wrdrive: assert property (p_wrdrive) else $error("write idle");
  a_rdearly: assert property (p_rdearly) else $error("read head");
  a_rdrel: assert property (p_rdrel) else $error("read not freed");
  a_frame: assert property (p_frame) else $error("frame length");
  c_tx: cover property (txValid && txReady);
  c_rx: cover property (rxValid);
  c_rd: cover property ($fell(mgmtBusy) && mgmtRead);
endmodule
`default_nettype wire

// >>> phy_model.sv
// PHY model: free-running PHY clocks, receive bytes, one register.
// Assumes the bench resolves the shared management line.
`timescale 1ns/10ps
`default_nettype none
module phy_model (
  input  wire logic       mdc,
  input  wire logic       mdioLine,
  output var  logic       mdioDrv,
  output var  logic       mdioDrvEn,
  output var  logic       phyTxClk,
  output var  logic       phyRxClk,
  output var  logic [7:0] phyRxd,
  output var  logic       phyRxDv,
  output var  logic       phyRxEr
);
  // ****************************************
  // Behaviour
  // ****************************************
  logic [15:0] regVal = 16'h0000;
  logic [62:0] shift = '0;
  int          bitNum = 0;
  int          ones = 0;
  logic        active = 1'b0;
  logic        isRead = 1'b0;
  initial begin
    {mdioDrv, mdioDrvEn, phyTxClk, phyRxClk, phyRxDv, phyRxEr} = 6'h00;
    phyRxd = 8'h00;
  end
  always #20 phyRxClk = ~phyRxClk;
  always #20 phyTxClk = ~phyTxClk;
  // Frames are found from the preamble, as a real PHY must.
  always @(posedge mdc) begin
    shift = {shift[61:0], mdioLine};
    if (active) begin
      bitNum++;
      if (bitNum == 35) isRead = shift[1] & !shift[0];
      if (bitNum == 63) begin
        active = 1'b0;
        ones = 0;
        if (!isRead) regVal = shift[15:0];
      end
    end else if (!mdioLine && ones >= 32) begin
      active = 1'b1;
      bitNum = 32;
    end else ones = mdioLine ? ones + 1 : 0;
  end
  always @(negedge mdc) begin
    mdioDrvEn <= active && isRead && bitNum >= 47 && bitNum < 63;
    mdioDrv   <= regVal[(62 - bitNum) & 15];
  end
  // Idle data is inverted so stale bytes never pass for fresh ones.
  task automatic rxByte(input logic [7:0] b, input logic dv);
    @(negedge phyRxClk);
    phyRxd  = dv ? b : ~phyRxd;
    phyRxDv = dv;
  endtask
endmodule
`default_nettype wire

// >>> mac_phy_mgmt_interface_test.sv
// Self-checking bench for the PHY-side shell in byte-wide mode.
// Assumes the PHY model supplies PHY clocks and the management slave.
`timescale 1ns/10ps
`default_nettype none
module mac_phy_mgmt_interface_test;
  // ****************************************
  // Stimulus and checks
  // ****************************************
  logic        clock, reset_n, cfgTxEnable, cfgRxEnable, cfgTxReset;
  logic        cfgRxReset, txValid, txLast, txUserErr, txReady, rxValid;
  logic        rxErr, rxLast, speed_hundred_ind, speed_low_rate_ind;
  logic        phyTxEn, phyTxEr, phyTxClk, phyRxClk, phyRxDv, phyRxEr;
  logic        inbandLinkStatus, inbandDuplexStatus, mgmtStart, mgmtRead;
  logic        mgmtBusy, mdc, mdioIn, mdioOut, mdioTristate, drv, drvEn;
  logic        gtxTick = 1'h0;
  logic [1:0]  cfgSpeed, inbandClockSpeed, tc = 2'h0;
  logic [5:0]  cfgMdcDivide;
  logic [7:0]  txData, rxData, phyTxd, phyRxd;
  logic [4:0]  mgmtPhyAddr = 5'h01, mgmtRegAddr = 5'h02;
  logic [15:0] mgmtWrData, mgmtRdData;
  logic [7:0]  rxSeen [$];
  int          badCount, nCompared, cycles, rxLastCnt;
  mac_phy_mgmt_interface dut (.clock, .reset_n, .cfgSpeed, .cfgTxEnable,
    .cfgRxEnable, .cfgTxReset, .cfgRxReset, .cfgMdcDivide, .gtxTick,
    .txValid, .txData, .txLast, .txUserErr, .txReady, .rxValid, .rxData,
    .rxErr, .rxLast, .speed_hundred_ind, .speed_low_rate_ind, .phyTxd,
    .phyTxEn, .phyTxEr, .phyTxClk, .phyRxClk, .phyRxd, .phyRxDv, .phyRxEr,
    .inbandLinkStatus, .inbandClockSpeed, .inbandDuplexStatus, .mgmtStart,
    .mgmtRead, .mgmtPhyAddr, .mgmtRegAddr, .mgmtWrData, .mgmtBusy,
    .mgmtRdData, .mdc, .mdioIn, .mdioOut, .mdioTristate);
  phy_model phy (.mdc, .mdioLine(mdioIn), .mdioDrv(drv), .mdioDrvEn(drvEn),
    .phyTxClk, .phyRxClk, .phyRxd, .phyRxDv, .phyRxEr);
  assign mdioIn = !mdioTristate ? (drvEn ? 1'hx : mdioOut)
                                : (drvEn ? drv : 1'h1);
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    #1;
    tc = tc + 2'h1;
    gtxTick = (tc == 2'h0);
  end
  always @(posedge clock) begin
    if (rxValid === 1'h1) rxSeen.push_back(rxData);
    if (rxLast === 1'h1) rxLastCnt++;
    if (++cycles == 20000) begin
      badCount++;
      reportAndStop();
    end
  end
  task automatic chk(input string nm, input logic [15:0] exp, got);
    nCompared++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic reportAndStop();
    $display("compared %0d mismatches %0d", nCompared, badCount);
    if (badCount == 0 && nCompared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic txByte(input logic [7:0] b, input logic lst, err);
    int n;
    {txValid, txData, txLast, txUserErr} = {1'h1, b, lst, err};
    n = 0;
    do @(negedge clock); while (txReady !== 1'h1 && ++n < 20);
    @(posedge clock);
    #1;
    chk("phyTxd", b, phyTxd);
    chk("phyTxEr", err, phyTxEr);
  endtask
  task automatic mgmtOp(input logic rd, input logic [15:0] wd);
    int n;
    @(posedge clock);
    #1;
    {mgmtStart, mgmtRead, mgmtWrData} = {1'h1, rd, wd};
    n = 0;
    do @(negedge clock); while (mgmtBusy !== 1'h1 && ++n < 50);
    @(posedge clock);
    #1;
    mgmtStart = 1'h0;
    // The negedge that first saw busy is its first cycle.
    n = 1;
    do @(negedge clock); while (mgmtBusy !== 1'h0 && ++n < 1000);
    chk("busyCycles", 16'h0200, n[15:0]);
  endtask
  task automatic txTest();
    @(posedge clock);
    #1;
    {cfgTxEnable, txValid, txData} = {1'h0, 1'h1, 8'h3C};
    repeat (8) @(negedge clock) chk("txReadyOff", 1'h0, txReady);
    @(posedge clock);
    #1;
    {cfgTxEnable, cfgTxReset} = 2'h3;
    repeat (8) @(negedge clock) chk("txReadyRst", 1'h0, txReady);
    @(posedge clock);
    #1;
    cfgTxReset = 1'h0;
    txByte(8'hA5, 1'h0, 1'h0);
    cfgTxEnable = 1'h0;
    txByte(8'h5A, 1'h0, 1'h1);
    txByte(8'hFF, 1'h1, 1'h0);
    {cfgSpeed, cfgTxEnable} = 3'h3;
    txByte(8'h96, 1'h1, 1'h0);
    chk("txClkHigh", 1'h1, phyTxClk);
    {txValid, cfgTxEnable} = 2'h1;
    repeat (12) @(posedge clock);
    #1 chk("phyTxEn", 1'h0, phyTxEn);
  endtask
  task automatic rxTest();
    rxSeen.delete();
    rxLastCnt = 0;
    phy.rxByte(8'h55, 1'h1);
    phy.rxByte(8'hD5, 1'h1);
    phy.rxByte(8'h0F, 1'h1);
    phy.rxByte(8'h00, 1'h0);
    repeat (20) @(posedge clock);
    chk("rxCount", 16'h0003, 16'(rxSeen.size()));
    chk("rxByte1", 8'hD5, rxSeen[1]);
    chk("rxLast", 16'h0001, 16'(rxLastCnt));
    #1;
    cfgRxEnable = 1'h0;
    rxSeen.delete();
    phy.rxByte(8'h11, 1'h1);
    phy.rxByte(8'h22, 1'h1);
    @(posedge clock);
    #1;
    cfgRxEnable = 1'h1;
    phy.rxByte(8'h00, 1'h0);
    repeat (20) @(posedge clock);
    chk("rxDropped", 16'h0000, 16'(rxSeen.size()));
  endtask
  task automatic mgmtTest();
    #1;
    {cfgMdcDivide, mgmtStart, mgmtRead} = {6'h00, 1'h1, 1'h0};
    repeat (40) @(negedge clock);
    chk("busyNoDiv", 1'h0, mgmtBusy);
    @(posedge clock);
    #1;
    {cfgMdcDivide, mgmtStart} = {6'h03, 1'h0};
    mgmtOp(1'h0, 16'hC3A5);
    mgmtOp(1'h1, 16'h0000);
    chk("rdData", 16'hC3A5, mgmtRdData);
  endtask
  initial begin
    {reset_n, cfgTxEnable, cfgRxEnable, cfgTxReset, cfgRxReset} = 5'h00;
    {txValid, txLast, txUserErr, mgmtStart, mgmtRead} = 5'h00;
    {cfgSpeed, cfgMdcDivide, txData, mgmtWrData} = {2'h2, 6'h03, 24'h0};
    repeat (5) @(posedge clock);
    #1 reset_n = 1'h1;
    chk("tristate", 1'h1, mdioTristate);
    chk("phyTxEnRst", 1'h0, phyTxEn);
    {cfgTxEnable, cfgRxEnable} = 2'h3;
    for (int s = 0; s < 3; s++) begin
      @(posedge clock);
      #1;
      cfgSpeed = s[1:0];
      @(negedge clock);
      chk("hundred", s == 1, speed_hundred_ind);
      chk("lowRate", s <= 1, speed_low_rate_ind);
    end
    txTest();
    rxTest();
    mgmtTest();
    reportAndStop();
  end
endmodule
bind mac_phy_mgmt_interface mac_phy_mgmt_interface_sva chk (.clock,
  .reset_n, .cfgSpeed, .cfgTxReset, .txValid, .txReady, .txData,
  .txUserErr, .phyTxd, .phyTxEn, .phyTxEr, .rxValid, .speed_hundred_ind,
  .speed_low_rate_ind, .mgmtRead, .mgmtBusy, .mdc, .mdioTristate);
`default_nettype wire
